// ==== hpm_regs.sv ====
// i2c-reached control bank for headphone driver, mic bias and input common mode
`timescale 1ns/1ps
module hpm_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h2a, // arbitrary bus address
    parameter int VALID_CYCLES = hpm_pkg::VALID_CYCLES
) (
    input wire logic CLOCK_IN,
    input wire logic RST_IN,
    input wire logic SOFT_RESET_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N_OUT,
    input wire logic OSC_IN,
    input wire logic HS_SHORT_IN,
    input wire logic HS_DETECT_EN_IN,
    input wire logic HS_INSERTED_IN,
    output hpm_pkg::hpm_ctrl_t ANALOG_CTRL_OUT,
    output logic DEFAULTS_VALID_OUT
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [2:0] scl_s, sda_s;
    logic [1:0] osc_s, short_s, det_s, ins_s;
    logic osc_prev_r;
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            osc_s <= 2'h0;
            short_s <= 2'h0;
            det_s <= 2'h0;
            ins_s <= 2'h0;
            osc_prev_r <= 1'b0;
        end else begin
            scl_s <= {scl_s[1:0], SCL_IN};
            sda_s <= {sda_s[1:0], SDA_IN};
            osc_s <= {osc_s[0], OSC_IN};
            short_s <= {short_s[0], HS_SHORT_IN};
            det_s <= {det_s[0], HS_DETECT_EN_IN};
            ins_s <= {ins_s[0], HS_INSERTED_IN};
            osc_prev_r <= osc_s[1];
        end
    end
    wire scl_rise = scl_s[1] & ~scl_s[2];
    wire scl_fall = ~scl_s[1] & scl_s[2];
    wire bus_start = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
    wire bus_stop = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
    // ************************************************************
    // serial control slave
    // ************************************************************
    hpm_pkg::hpm_state_t state_r, after_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r, ptr_r, rd_data;
    logic sda_oe_n_r, wr_fire_r;
    logic [7:0] wr_addr_r, wr_data_r;
    wire byte_done = bit_cnt_r == hpm_pkg::I2C_BYTE_BITS;
    wire addr_hit = shift_r[7:1] == DEV_ADDR;
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_r <= hpm_pkg::ST_IDLE;
            after_r <= hpm_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            ptr_r <= 8'h00;
            sda_oe_n_r <= 1'b1;
            wr_fire_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
        end else begin
            wr_fire_r <= 1'b0;
            if (bus_start) begin
                state_r <= hpm_pkg::ST_ADDR;
                bit_cnt_r <= 4'h0;
                sda_oe_n_r <= 1'b1;
            end else if (bus_stop) begin
                state_r <= hpm_pkg::ST_IDLE;
                sda_oe_n_r <= 1'b1;
            end else begin
                unique case (state_r)
                    hpm_pkg::ST_IDLE: begin
                        sda_oe_n_r <= 1'b1;
                    end
                    hpm_pkg::ST_ADDR, hpm_pkg::ST_PTR, hpm_pkg::ST_WR: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_s[1]};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && byte_done) begin
                            state_r <= hpm_pkg::ST_ACK;
                            sda_oe_n_r <= 1'b0;
                            if (state_r == hpm_pkg::ST_ADDR) begin
                                if (!addr_hit) begin
                                    state_r <= hpm_pkg::ST_IDLE;
                                    sda_oe_n_r <= 1'b1;
                                end
                                after_r <= shift_r[0] ? hpm_pkg::ST_RD : hpm_pkg::ST_PTR;
                            end else if (state_r == hpm_pkg::ST_PTR) begin
                                ptr_r <= shift_r;
                                after_r <= hpm_pkg::ST_WR;
                            end else begin
                                wr_fire_r <= 1'b1;
                                wr_addr_r <= ptr_r;
                                wr_data_r <= shift_r;
                                ptr_r <= ptr_r + 8'h01;
                                after_r <= hpm_pkg::ST_WR;
                            end
                        end
                    end
                    hpm_pkg::ST_ACK: begin
                        if (scl_fall) begin
                            state_r <= after_r;
                            bit_cnt_r <= 4'h0;
                            shift_r <= rd_data;
                            sda_oe_n_r <= (after_r == hpm_pkg::ST_RD) ? rd_data[7] : 1'b1;
                        end
                    end
                    hpm_pkg::ST_RD: begin
                        if (scl_rise) begin
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && byte_done) begin
                            state_r <= hpm_pkg::ST_RACK;
                            sda_oe_n_r <= 1'b1;
                            ptr_r <= ptr_r + 8'h01;
                        end else if (scl_fall) begin
                            sda_oe_n_r <= shift_r[6];
                            shift_r <= {shift_r[6:0], 1'b0};
                        end
                    end
                    hpm_pkg::ST_RACK: begin
                        // a master nack ends the read; an ack fetches the next byte
                        if (scl_rise) begin
                            state_r <= sda_s[1] ? hpm_pkg::ST_IDLE : hpm_pkg::ST_ACK;
                            after_r <= hpm_pkg::ST_RD;
                        end
                    end
                    default: begin
                        state_r <= hpm_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end
    // ************************************************************
    // register file
    // ************************************************************
    logic [7:0] page_r, hp_ctl_r, bias_r, cm_r, tdiv_r;
    wire on_analog = page_r == hpm_pkg::PAGE_ANALOG;
    wire on_timer = page_r == hpm_pkg::PAGE_TIMER;
    wire wr_page = wr_fire_r && wr_addr_r == hpm_pkg::REG_PAGE_SELECT;
    wire wr_hp = wr_fire_r && on_analog && wr_addr_r == hpm_pkg::REG_HEADPHONE_DRIVER_CONTROL;
    wire wr_bias = wr_fire_r && on_analog && wr_addr_r == hpm_pkg::REG_BIAS_AND_POWER_DOWN;
    wire wr_cm = wr_fire_r && on_analog && wr_addr_r == hpm_pkg::REG_INPUT_COMMON_MODE;
    wire wr_tdiv = wr_fire_r && on_timer && wr_addr_r == hpm_pkg::REG_TIMER_CLOCK_DIV;
    // reserved locations read zero and drop writes, so register 45 holds nothing
    assign rd_data = (ptr_r == hpm_pkg::REG_PAGE_SELECT) ? page_r :
                     (on_analog && ptr_r == hpm_pkg::REG_HEADPHONE_DRIVER_CONTROL) ? hp_ctl_r :
                     (on_analog && ptr_r == hpm_pkg::REG_BIAS_AND_POWER_DOWN) ? bias_r :
                     (on_analog && ptr_r == hpm_pkg::REG_INPUT_COMMON_MODE) ? cm_r :
                     (on_timer && ptr_r == hpm_pkg::REG_TIMER_CLOCK_DIV) ? tdiv_r : 8'h00;
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            page_r <= hpm_pkg::RST_PAGE;
            hp_ctl_r <= hpm_pkg::RST_HP_CTL;
            bias_r <= hpm_pkg::RST_BIAS;
            cm_r <= hpm_pkg::RST_CM;
            tdiv_r <= hpm_pkg::RST_TIMER_DIV;
        end else if (SOFT_RESET_IN) begin
            page_r <= hpm_pkg::RST_PAGE;
            hp_ctl_r <= hpm_pkg::RST_HP_CTL;
            bias_r <= hpm_pkg::RST_BIAS;
            cm_r <= hpm_pkg::RST_CM;
            tdiv_r <= hpm_pkg::RST_TIMER_DIV;
        end else begin
            if (wr_page) page_r <= wr_data_r;
            if (wr_hp) hp_ctl_r <= wr_data_r;
            if (wr_bias) bias_r <= wr_data_r;
            if (wr_cm) cm_r <= wr_data_r;
            if (wr_tdiv) tdiv_r <= wr_data_r;
        end
    end
    // ************************************************************
    // delay timer tick and debounce
    // ************************************************************
    logic [7:0] ext_cnt_r;
    logic [2:0] osc_cnt_r;
    logic tick_r;
    logic [6:0] deb_cnt_r;
    logic [3:0] miss_cnt_r;
    logic short_r;
    wire [7:0] div_ratio = (tdiv_r[hpm_pkg::TDIV_MSB:0] == 7'h00) ?
                           hpm_pkg::DIV_ZERO_RATIO : {1'b0, tdiv_r[hpm_pkg::TDIV_MSB:0]};
    wire ext_tick = ext_cnt_r == div_ratio - 8'h01;
    // the oscillator prescale by eight makes every debounce time track its frequency
    wire osc_tick = osc_s[1] & ~osc_prev_r & (osc_cnt_r == hpm_pkg::OSC_PRESCALE_LAST);
    wire tick_nxt = tdiv_r[hpm_pkg::TSRC_BIT] ? ext_tick : osc_tick;
    wire [2:0] deb_code = hp_ctl_r[hpm_pkg::DEB_MSB:hpm_pkg::DEB_LSB];
    wire [6:0] deb_last = 7'(7'h01 << (deb_code - 3'h1)) - 7'h01;
    wire deb_en = tick_r && deb_cnt_r >= deb_last;
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ext_cnt_r <= 8'h00;
            osc_cnt_r <= 3'h0;
            tick_r <= 1'b0;
            deb_cnt_r <= 7'h00;
            miss_cnt_r <= 4'h0;
            short_r <= 1'b0;
        end else begin
            ext_cnt_r <= ext_tick ? 8'h00 : ext_cnt_r + 8'h01;
            if (osc_s[1] & ~osc_prev_r) osc_cnt_r <= osc_cnt_r + 3'h1;
            tick_r <= tick_nxt;
            if (tick_r) deb_cnt_r <= deb_en ? 7'h00 : deb_cnt_r + 7'h01;
            if (deb_code == 3'h0) begin
                short_r <= short_s[1];
                miss_cnt_r <= 4'h0;
            end else if (deb_en) begin
                // eight debounce clocks make the selected time: 8 us doubling to 512 us
                if (short_s[1] == short_r) begin
                    miss_cnt_r <= 4'h0;
                end else if (miss_cnt_r == hpm_pkg::DEB_SAMPLES - 4'h1) begin
                    short_r <= short_s[1];
                    miss_cnt_r <= 4'h0;
                end else begin
                    miss_cnt_r <= miss_cnt_r + 4'h1;
                end
            end
        end
    end
    // ************************************************************
    // analog control outputs and reset-default validity
    // ************************************************************
    logic [14:0] valid_cnt_r;
    logic valid_r;
    hpm_pkg::hpm_ctrl_t ctrl_r;
    wire bias_gate = bias_r[hpm_pkg::BIAS_FORCE_BIT] | ~det_s[1] | ins_s[1];
    wire [1:0] perf = hp_ctl_r[hpm_pkg::PERF_MSB:hpm_pkg::PERF_LSB];
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            valid_cnt_r <= 15'h0000;
            valid_r <= 1'b0;
            ctrl_r <= '0;
        end else begin
            if (SOFT_RESET_IN) begin
                valid_cnt_r <= 15'h0000;
                valid_r <= 1'b0;
            end else if (32'(valid_cnt_r) >= VALID_CYCLES - 1) begin
                valid_r <= 1'b1;
            end else begin
                valid_cnt_r <= valid_cnt_r + 15'h0001;
            end
            ctrl_r.sw_power_down <= bias_r[hpm_pkg::SWPD_BIT];
            ctrl_r.bias_level <= bias_gate ?
                bias_r[hpm_pkg::BIAS_LVL_MSB:hpm_pkg::BIAS_LVL_LSB] : 2'h0;
            ctrl_r.perf_code <= perf;
            ctrl_r.perf_boost <= perf[0];
            ctrl_r.hp_driver_on <= hp_ctl_r[hpm_pkg::HP_ON_BIT];
            ctrl_r.hp_short <= short_r;
            ctrl_r.cm_analog_input_one <= cm_r[hpm_pkg::CM_ANALOG_INPUT_ONE_BIT];
            ctrl_r.cm_analog_input_two <= cm_r[hpm_pkg::CM_ANALOG_INPUT_TWO_BIT];
        end
    end
    assign ANALOG_CTRL_OUT = ctrl_r;
    assign DEFAULTS_VALID_OUT = valid_r;
    assign SDA_OE_N_OUT = sda_oe_n_r;
    // open drain: the pin only ever pulls low
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) SDA_OUT <= 1'b0;
        else SDA_OUT <= 1'b0;
    end
    // ************************************************************
    // assertions
    // ************************************************************
    property p_page_write;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        wr_page && !SOFT_RESET_IN |=> page_r == $past(wr_data_r);
    endproperty
    a_page_write: assert property (p_page_write) else $error("page write lost");
    property p_page_any;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        wr_fire_r && wr_addr_r == hpm_pkg::REG_PAGE_SELECT && !SOFT_RESET_IN
            |=> page_r == $past(wr_data_r);
    endproperty
    a_page_any: assert property (p_page_any) else $error("page not reachable");
    property p_bias_gate;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        det_s[1] && !ins_s[1] && !bias_r[3] |=> ctrl_r.bias_level == 2'h0;
    endproperty
    a_bias_gate: assert property (p_bias_gate) else $error("bias on without headset");
    property p_bias_level;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        bias_r[3] |=> ctrl_r.bias_level == $past(bias_r[1:0]);
    endproperty
    a_bias_level: assert property (p_bias_level) else $error("bias level wrong");
    property p_swpd;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        ##1 ctrl_r.sw_power_down == $past(bias_r[7]);
    endproperty
    a_swpd: assert property (p_swpd) else $error("power-down mismatch");
    property p_perf;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        ##1 ctrl_r.perf_boost == ($past(perf) == 2'h1 || $past(perf) == 2'h3);
    endproperty
    a_perf: assert property (p_perf) else $error("perf decode wrong");
    property p_cm;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        ##1 {ctrl_r.cm_analog_input_one, ctrl_r.cm_analog_input_two} == $past(cm_r[7:6]);
    endproperty
    a_cm: assert property (p_cm) else $error("common mode mismatch");
    property p_div128;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        tdiv_r == 8'h80 && ext_tick ##1 tdiv_r == 8'h80 |-> !ext_tick [*8];
    endproperty
    a_div128: assert property (p_div128) else $error("divider too fast");
    property p_valid;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        valid_r |-> 32'(valid_cnt_r) >= VALID_CYCLES - 1;
    endproperty
    a_valid: assert property (p_valid) else $error("defaults valid too early");
    property p_deb_zero;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        deb_code == 3'h0 |=> short_r == $past(short_s[1]);
    endproperty
    a_deb_zero: assert property (p_deb_zero) else $error("zero debounce delayed");
endmodule

// ==== hpm_pkg.sv ====
// constants and types for the headphone, mic bias and common-mode control bank
//
// Function
// - 1-MHz source: debounce codes 0, 8..512 us
// - oscillator source: codes scale with 8.2 MHz
// - debounce clock period is duration over eight
// - timer source bit; divider code zero means 128
// - perf field: 01 and 11 raise DAC current
// - bias bit 7 enables software power-down
// - with detect enabled, bias gated off unless headset or force
// - bias level: off, 2 V, 2.5 V, supply
// - bits 7,6 tie unused inputs to common mode
// - page register at zero, resets to zero
// - defaults valid only 100 us after reset
package hpm_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] REG_PAGE_SELECT = 8'h00;
    localparam logic [7:0] REG_HEADPHONE_DRIVER_CONTROL = 8'h2c;
    localparam logic [7:0] REG_RESERVED_BLOCK_A = 8'h2d;
    localparam logic [7:0] REG_BIAS_AND_POWER_DOWN = 8'h2e;
    localparam logic [7:0] REG_INPUT_COMMON_MODE = 8'h32;
    localparam logic [7:0] REG_TIMER_CLOCK_DIV = 8'h10;
    localparam logic [7:0] PAGE_ANALOG = 8'h01;
    localparam logic [7:0] PAGE_TIMER = 8'h03;
    // ************************************************************
    // reset values and field positions
    // ************************************************************
    localparam logic [7:0] RST_PAGE = 8'h00;
    localparam logic [7:0] RST_HP_CTL = 8'h00;
    localparam logic [7:0] RST_BIAS = 8'h00;
    localparam logic [7:0] RST_CM = 8'h00;
    localparam logic [7:0] RST_TIMER_DIV = 8'h80;
    localparam int DEB_MSB = 7;
    localparam int DEB_LSB = 5;
    localparam int PERF_MSB = 4;
    localparam int PERF_LSB = 3;
    localparam int HP_ON_BIT = 2;
    localparam int SWPD_BIT = 7;
    localparam int BIAS_FORCE_BIT = 3;
    localparam int BIAS_LVL_MSB = 1;
    localparam int BIAS_LVL_LSB = 0;
    localparam int CM_ANALOG_INPUT_ONE_BIT = 7;
    localparam int CM_ANALOG_INPUT_TWO_BIT = 6;
    localparam int TSRC_BIT = 7;
    localparam int TDIV_MSB = 6;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ = 250;
    localparam int VALID_TIME_US = 100;
    localparam int VALID_CYCLES = VALID_TIME_US * CLK_MHZ;
    localparam logic [7:0] DIV_ZERO_RATIO = 8'h80;
    localparam logic [2:0] OSC_PRESCALE_LAST = 3'h7;
    localparam logic [3:0] DEB_SAMPLES = 4'h8;
    localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_PTR = 3'b010,
        ST_WR = 3'b011,
        ST_RD = 3'b100,
        ST_RACK = 3'b101,
        ST_ACK = 3'b110
    } hpm_state_t;
    typedef struct packed {
        logic sw_power_down;
        logic [1:0] bias_level;
        logic [1:0] perf_code;
        logic perf_boost;
        logic hp_driver_on;
        logic hp_short;
        logic cm_analog_input_one;
        logic cm_analog_input_two;
    } hpm_ctrl_t;
endpackage

// ==== hpm_host.sv ====
// i2c host model that reaches the register bank over scl and sda
`timescale 1ns/1ps
module hpm_host (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_rel_out
);
    // ****************************************
    // bus phases
    // ****************************************
    initial begin
        scl_out = 1'b1;
        sda_rel_out = 1'b1;
    end
    // 8 clocks a phase, twice what the synchronisers need
    task automatic half();
        repeat (8) @(negedge clk_in);
    endtask
    // also serves as repeated start
    task automatic start_c();
        sda_rel_out = 1'b1;
        half();
        scl_out = 1'b1;
        half();
        sda_rel_out = 1'b0;
        half();
        scl_out = 1'b0;
    endtask
    task automatic stop_c();
        sda_rel_out = 1'b0;
        half();
        scl_out = 1'b1;
        half();
        sda_rel_out = 1'b1;
        half();
    endtask
    // data only moves while scl is low; sampled late in the high phase
    task automatic bit_c(input logic b, output logic s);
        sda_rel_out = b;
        half();
        scl_out = 1'b1;
        half();
        s = sda_in;
        scl_out = 1'b0;
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(d[i], s);
        end
        bit_c(1'b1, s);
        ack = ~s;
    endtask
    task automatic get(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(1'b1, d[i]);
        end
        bit_c(nack, s);
    endtask
endmodule

// ==== tb.sv ====
// self-checking testbench for the headphone, bias and common-mode bank
`timescale 1ns/1ps
module tb;
    localparam int VALID_N = 50;
    localparam logic [6:0] ADDR = 7'h2a;
    logic clk, rst, soft_rst, osc, hs_short, hs_det, hs_ins;
    logic scl, sda_rel, sda_out, sda_oe_n, dvalid, sda_w, ack;
    logic [7:0] v;
    hpm_pkg::hpm_ctrl_t ctrl;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    // pull-up: low when either party pulls
    assign sda_w = sda_rel & (sda_oe_n | sda_out);
    hpm_regs #(.DEV_ADDR(ADDR), .VALID_CYCLES(VALID_N)) dut (.CLOCK_IN(clk), .RST_IN(rst),
        .SOFT_RESET_IN(soft_rst), .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_out),
        .SDA_OE_N_OUT(sda_oe_n), .OSC_IN(osc), .HS_SHORT_IN(hs_short),
        .HS_DETECT_EN_IN(hs_det), .HS_INSERTED_IN(hs_ins), .ANALOG_CTRL_OUT(ctrl),
        .DEFAULTS_VALID_OUT(dvalid));
    hpm_host host (.clk_in(clk), .sda_in(sda_w), .scl_out(scl), .sda_rel_out(sda_rel));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // free-running oscillator near 8.2 MHz, unrelated to clk
    initial begin
        osc = 1'b0;
        forever #61 osc = ~osc;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            summarize();
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic summarize();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic k1, k2, k3;
        host.start_c();
        host.put({ADDR, 1'b0}, k1);
        host.put(a, k2);
        host.put(d, k3);
        host.stop_c();
        chk("write acks", {k1, k2, k3}, 10'h7);
    endtask
    task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic k1, k2, k3;
        logic [7:0] d;
        host.start_c();
        host.put({ADDR, 1'b0}, k1);
        host.put(a, k2);
        host.start_c();
        host.put({ADDR, 1'b1}, k3);
        host.get(1'b1, d);
        host.stop_c();
        chk("read acks", {k1, k2, k3}, 10'h7);
        chk(name, d, exp);
    endtask
    // flips the short input and checks it is held, then passed on
    task automatic deb(input logic [7:0] tsrc, input logic [2:0] code, input int early,
        input int late);
        logic old, nv;
        wr(hpm_pkg::REG_PAGE_SELECT, hpm_pkg::PAGE_TIMER);
        wr(hpm_pkg::REG_TIMER_CLOCK_DIV, tsrc);
        wr(hpm_pkg::REG_PAGE_SELECT, hpm_pkg::PAGE_ANALOG);
        wr(hpm_pkg::REG_HEADPHONE_DRIVER_CONTROL, {code, 5'h00});
        old = ctrl.hp_short;
        nv = ~old;
        hs_short = nv;
        repeat (early) @(negedge clk);
        chk("short held", ctrl.hp_short, old);
        repeat (late - early) @(negedge clk);
        chk("short passed", ctrl.hp_short, nv);
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        soft_rst = 1'b0;
        hs_short = 1'b0;
        hs_det = 1'b0;
        hs_ins = 1'b0;
        repeat (20) @(negedge clk);
        chk("reset oe_n", sda_oe_n, 10'h1);
        chk("reset ctrl", ctrl, 10'h0);
        rst = 1'b0;
        repeat (VALID_N - 5) @(negedge clk);
        chk("valid early", dvalid, 10'h0);
        repeat (10) @(negedge clk);
        chk("valid late", dvalid, 10'h1);
        rd("page reset", 8'h00, 8'h00);
        host.start_c();
        host.put({7'h2b, 1'b0}, ack);
        host.stop_c();
        chk("foreign address ack", ack, 10'h0);
        wr(8'h00, 8'hff);
        rd("page 255", 8'h00, 8'hff);
        wr(8'h00, hpm_pkg::PAGE_ANALOG);
        rd("hp reset", 8'h2c, 8'h00);
        rd("bias reset", 8'h2e, 8'h00);
        rd("cm reset", 8'h32, 8'h00);
        rd("reserved 45", 8'h2d, 8'h00);
        // reserved registers are only ever read, never written
        rd("reserved 47", 8'h2f, 8'h00);
        // low bits are 3'h4 in every write of this loop: only the driver-on bit is set
        for (int p = 0; p < 4; p++) begin
            wr(8'h2c, {3'h0, p[1:0], 3'h4});
            chk("perf code", ctrl.perf_code, p[1:0]);
            chk("perf boost", ctrl.perf_boost, p == 1 || p == 3);
            chk("hp driver on", ctrl.hp_driver_on, 10'h1);
        end
        hs_det = 1'b1;
        for (int l = 0; l < 4; l++) begin
            wr(8'h2e, {1'b1, 5'h00, l[1:0]});
            chk("bias gated", ctrl.bias_level, 10'h0);
            chk("sw power-down set", ctrl.sw_power_down, 10'h1);
            hs_ins = 1'b1;
            repeat (8) @(negedge clk);
            chk("bias level", ctrl.bias_level, l[1:0]);
            hs_ins = 1'b0;
            wr(8'h2e, {4'h0, 1'b1, 1'b0, l[1:0]});
            chk("bias forced", ctrl.bias_level, l[1:0]);
            chk("sw power-down clear", ctrl.sw_power_down, 10'h0);
        end
        for (int c = 0; c < 4; c++) begin
            wr(8'h32, {c[1:0], 6'h00});
            chk("cm inputs", {ctrl.cm_analog_input_one, ctrl.cm_analog_input_two}, c[1:0]);
        end
        rd("cm readback", 8'h32, 8'hc0);
        deb(8'h81, 3'h3, 24, 44);
        deb(8'h81, 3'h0, 1, 8);
        deb(8'h80, 3'h1, 800, 1300);
        deb(8'h00, 3'h1, 1500, 2400);
        wr(8'h00, hpm_pkg::PAGE_TIMER);
        rd("page on page 3", 8'h00, 8'h03);
        soft_rst = 1'b1;
        @(negedge clk);
        soft_rst = 1'b0;
        repeat (3) @(negedge clk);
        chk("soft reset ctrl", ctrl, 10'h0);
        chk("soft reset valid", dvalid, 10'h0);
        repeat (VALID_N + 5) @(negedge clk);
        chk("soft valid late", dvalid, 10'h1);
        rd("soft page", 8'h00, 8'h00);
        wr(8'h00, hpm_pkg::PAGE_TIMER);
        rd("timer reset", 8'h10, 8'h80);
        summarize();
    end
endmodule
